// ### design/raac_pkg.sv
// Package for receive address activation control
// Assumes a single 100 MHz clock domain
package raac_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CHAN_W = 3;
  localparam int ADDR_W = 8;
  localparam int WORD_W = 16;
  // Output word field positions
  localparam int OW_XFER_BIT = 15;
  localparam int OW_CHAN_HI = 10;
  localparam int OW_CHAN_LO = 8;
  localparam int OW_ADDR_HI = 7;
  localparam int OW_ADDR_LO = 0;
  // Input word field positions
  localparam int IW_SYNC_TOGGLE = 0;
  localparam int IW_ACTIVE = 1;
  localparam int IW_PULSE_MODE = 2;
  localparam int IW_SYNC_MONO = 3;
  localparam int IW_SYNC_ERR = 4;
  localparam int IW_PARAM_ERR = 5;
  localparam logic [WORD_W-1:0] IW_FIXED = 16'hf000;
  // Valid ranges of the receive channel and address, then reset values and config width
  localparam logic [CHAN_W-1:0] CHAN_MAX_DEF = 3'h7;
  localparam logic [ADDR_W-1:0] ADDR_MAX_DEF = 8'hc8;
  localparam logic [CHAN_W-1:0] CHAN_RESET = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
  localparam int CFG_W = 8;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

  typedef enum logic [1:0] {
    RAAC_INACTIVE = 2'b00,
    RAAC_WAIT_START = 2'b01,
    RAAC_RUN = 2'b11
  } raac_state_type;

  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [ADDR_W-1:0] addr;
  } raac_rxaddr_type;

  typedef struct packed {
    logic syncToggle;
    logic pulseMode;
    logic syncMono;
    logic syncErr;
  } raac_status_type;
endpackage : raac_pkg

// ### design/raac_sync.sv
// Two-flop synchroniser for a group of asynchronous levels
// Assumes inputs come from pins outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module raac_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = asyncIn;
    sync_d = meta_q;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign syncOut = sync_q;
endmodule // raac_sync
`default_nettype wire

// ### design/raac_core.sv
// Activation and receive address loading of the encoder module
// Assumes pins are asynchronous; ring and status inputs share the clock
`timescale 1ns/1ps
`default_nettype none
module raac_core
  import raac_pkg::*;
#(
  parameter logic [CHAN_W-1:0] CHAN_MAX = CHAN_MAX_DEF,
  parameter logic [ADDR_W-1:0] ADDR_MAX = ADDR_MAX_DEF
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic activation_switch,
  input wire logic [CHAN_W-1:0] channel_switch_bank,
  input wire logic [ADDR_W-1:0] address_switch_bank,
  input wire logic [CFG_W-1:0] configSwitches,
  input wire logic [WORD_W-1:0] host_output_word,
  input wire logic ringStartSeq,
  input wire raac_status_type encStatus,
  output raac_rxaddr_type rxAddr,
  output logic [CFG_W-1:0] configActive,
  output logic moduleActive,
  output logic pulseEnable,
  output logic ringNotActive,
  output logic paramError,
  output logic errorLed,
  output logic [WORD_W-1:0] host_input_word
);
  localparam int SYNC_W = 1 + CHAN_W + ADDR_W + CFG_W + WORD_W;

  logic [SYNC_W-1:0] syncBus;
  logic swLvl;
  logic [CHAN_W-1:0] chanSw;
  logic [ADDR_W-1:0] addrSw;
  logic [CFG_W-1:0] cfgSw;
  logic [WORD_W-1:0] outWord;
  logic xferBit;

  // Pins pass two flops first
  raac_sync #(.WIDTH(SYNC_W)) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .asyncIn({activation_switch, channel_switch_bank, address_switch_bank,
              configSwitches, host_output_word}),
    .syncOut(syncBus)
  );

  assign {swLvl, chanSw, addrSw, cfgSw, outWord} = syncBus;
  assign xferBit = outWord[OW_XFER_BIT];

  function automatic logic addrValid(input raac_rxaddr_type a);
    addrValid = (a.chan <= CHAN_MAX) && (a.addr <= ADDR_MAX);
  endfunction

  raac_state_type state_q, state_d;
  logic swPrev_q, swPrev_d;
  logic xferPrev_q, xferPrev_d;
  logic boot_q, boot_d;
  logic [1:0] settle_q, settle_d;
  raac_rxaddr_type rx_q, rx_d;
  logic [CFG_W-1:0] cfg_q, cfg_d;
  logic err_q, err_d;
  logic [WORD_W-1:0] iw_q, iw_d;
  logic wantActive;
  logic activating;
  raac_rxaddr_type combined;

  // Either source inactive keeps module off; bit needs switch on
  assign wantActive = swLvl & ~xferBit;

  always_comb begin
    combined.chan = chanSw | outWord[OW_CHAN_HI:OW_CHAN_LO];
    combined.addr = addrSw | outWord[OW_ADDR_HI:OW_ADDR_LO];
    activating = wantActive & ((swLvl & ~swPrev_q) | (xferPrev_q & ~xferBit));
    swPrev_d = swLvl;
    xferPrev_d = xferBit;
    // Boot load waits until the synchroniser holds real pin levels
    settle_d = {settle_q[0], 1'b0};
    boot_d = |settle_q;
    state_d = state_q;
    rx_d = rx_q;
    cfg_d = cfg_q;
    err_d = err_q;
    if (boot_q) begin
      // Power-up load from switches alone
      rx_d.chan = chanSw;
      rx_d.addr = addrSw;
      cfg_d = cfgSw;
      err_d = ~addrValid({chanSw, addrSw});
    end else if (state_q == RAAC_INACTIVE) begin
      // Deactivated: settings are tracked and taken up
      rx_d = combined;
      cfg_d = cfgSw;
      err_d = ~addrValid(combined);
    end
    case (state_q)
      RAAC_INACTIVE: begin
        if (activating || (boot_q && wantActive)) begin
          state_d = RAAC_WAIT_START;
        end
      end
      RAAC_WAIT_START: begin
        if (!wantActive) begin
          state_d = RAAC_INACTIVE;
        end else if (ringStartSeq && !err_q) begin
          state_d = RAAC_RUN;
        end
      end
      RAAC_RUN: begin
        if (!wantActive) begin
          state_d = RAAC_INACTIVE;
        end
      end
      default: state_d = RAAC_INACTIVE;
    endcase
    iw_d = IW_FIXED;
    iw_d[IW_SYNC_TOGGLE] = encStatus.syncToggle;
    iw_d[IW_ACTIVE] = (state_d != RAAC_INACTIVE);
    iw_d[IW_PULSE_MODE] = encStatus.pulseMode;
    iw_d[IW_SYNC_MONO] = encStatus.syncMono;
    iw_d[IW_SYNC_ERR] = encStatus.syncErr;
    iw_d[IW_PARAM_ERR] = err_d;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= RAAC_INACTIVE;
      swPrev_q <= 1'b0;
      xferPrev_q <= 1'b0;
      boot_q <= 1'b1;
      settle_q <= '1;
      rx_q <= '{chan: CHAN_RESET, addr: ADDR_RESET};
      cfg_q <= CFG_RESET;
      err_q <= 1'b0;
      iw_q <= IW_FIXED;
    end else begin
      state_q <= state_d;
      swPrev_q <= swPrev_d;
      xferPrev_q <= xferPrev_d;
      boot_q <= boot_d;
      settle_q <= settle_d;
      rx_q <= rx_d;
      cfg_q <= cfg_d;
      err_q <= err_d;
      iw_q <= iw_d;
    end
  end

  assign rxAddr = rx_q;
  assign configActive = cfg_q;
  assign moduleActive = (state_q != RAAC_INACTIVE);
  assign pulseEnable = (state_q == RAAC_RUN);
  assign ringNotActive = (state_q == RAAC_INACTIVE);
  assign paramError = err_q;
  assign errorLed = err_q;
  assign host_input_word = iw_q;

  // Assertions
  property p_frozen;
    @(posedge clock) disable iff (sys_rst)
      (state_q != RAAC_INACTIVE) && $past(state_q) != RAAC_INACTIVE && !$past(boot_q)
      |-> $stable(rxAddr) && $stable(configActive);
  endproperty
  a_frozen: assert property (p_frozen) else $error("Settings changed while active");

  property p_offWhenSource;
    @(posedge clock) disable iff (sys_rst)
      !wantActive |=> !pulseEnable && ringNotActive;
  endproperty
  a_offWhenSource: assert property (p_offWhenSource) else $error("Active with source off");

  property p_bitNeedsSwitch;
    @(posedge clock) disable iff (sys_rst)
      !swLvl |=> !moduleActive;
  endproperty
  a_bitNeedsSwitch: assert property (p_bitNeedsSwitch) else $error("Active with switch off");

  property p_swSeq;
    @(posedge clock) disable iff (sys_rst)
      (state_q == RAAC_INACTIVE) && !boot_q && !swPrev_q && swLvl && !xferBit
      |=> state_q == RAAC_WAIT_START;
  endproperty
  a_swSeq: assert property (p_swSeq) else $error("Switch sequence did not activate");

  property p_swOff;
    @(posedge clock) disable iff (sys_rst)
      !swLvl [*2] |-> !pulseEnable && !host_input_word[IW_ACTIVE];
  endproperty
  a_swOff: assert property (p_swOff) else $error("Not inactive with switch off");

  property p_orLoad;
    @(posedge clock) disable iff (sys_rst)
      (state_q == RAAC_INACTIVE) && !boot_q |=> rxAddr == $past(combined);
  endproperty
  a_orLoad: assert property (p_orLoad) else $error("Address not ORed");

  property p_errFlag;
    @(posedge clock) disable iff (sys_rst)
      ##1 errorLed == host_input_word[IW_PARAM_ERR] && errorLed == !addrValid(rxAddr);
  endproperty
  a_errFlag: assert property (p_errFlag) else $error("Error flag mismatch");

  property p_waitStart;
    @(posedge clock) disable iff (sys_rst)
      $rose(moduleActive) |-> !pulseEnable;
  endproperty
  a_waitStart: assert property (p_waitStart) else $error("Pulses before start");

  property p_bitSeq;
    @(posedge clock) disable iff (sys_rst)
      (state_q == RAAC_INACTIVE) && !boot_q && xferPrev_q && !xferBit && swLvl
      |=> state_q == RAAC_WAIT_START;
  endproperty
  a_bitSeq: assert property (p_bitSeq) else $error("Control bit sequence missed");

  property p_fixed;
    @(posedge clock) disable iff (sys_rst)
      host_input_word[WORD_W-1:IW_PARAM_ERR+1] == IW_FIXED[WORD_W-1:IW_PARAM_ERR+1];
  endproperty
  a_fixed: assert property (p_fixed) else $error("Fixed input word bits wrong");

  property p_bootLoad;
    @(posedge clock) disable iff (sys_rst)
      boot_q && !(|settle_q)
      |=> rxAddr.chan == $past(chanSw) && rxAddr.addr == $past(addrSw);
  endproperty
  a_bootLoad: assert property (p_bootLoad) else $error("Boot load not from switches");

  property p_cfgLoad;
    @(posedge clock) disable iff (sys_rst)
      (state_q == RAAC_INACTIVE) && !boot_q
      |=> configActive == $past(cfgSw);
  endproperty
  a_cfgLoad: assert property (p_cfgLoad) else $error("Config switches not reloaded");

  property p_chanBits;
    @(posedge clock) disable iff (sys_rst)
      (state_q == RAAC_INACTIVE) && !boot_q
      |=> rxAddr.chan == ($past(chanSw) | $past(outWord[OW_CHAN_HI:OW_CHAN_LO]));
  endproperty
  a_chanBits: assert property (p_chanBits) else $error("Channel bits misplaced");

  property p_addrBits;
    @(posedge clock) disable iff (sys_rst)
      (state_q == RAAC_INACTIVE) && !boot_q
      |=> rxAddr.addr == ($past(addrSw) | $past(outWord[OW_ADDR_HI:OW_ADDR_LO]));
  endproperty
  a_addrBits: assert property (p_addrBits) else $error("Address bits misplaced");

  property p_bitOff;
    @(posedge clock) disable iff (sys_rst)
      xferBit
      |=> !moduleActive && !host_input_word[IW_ACTIVE];
  endproperty
  a_bitOff: assert property (p_bitOff) else $error("Active with control bit set");

  property p_runAfterStart;
    @(posedge clock) disable iff (sys_rst)
      $rose(pulseEnable)
      |-> $past(ringStartSeq) && !$past(paramError);
  endproperty
  a_runAfterStart: assert property (p_runAfterStart) else $error("Run without start");

  property p_errNoRun;
    @(posedge clock) disable iff (sys_rst)
      paramError
      |-> !pulseEnable;
  endproperty
  a_errNoRun: assert property (p_errNoRun) else $error("Pulses with bad address");

  property p_statusCopy;
    @(posedge clock) disable iff (sys_rst)
      1'b1 |=> host_input_word[IW_SYNC_TOGGLE] == $past(encStatus.syncToggle)
        && host_input_word[IW_PULSE_MODE] == $past(encStatus.pulseMode)
        && host_input_word[IW_SYNC_MONO] == $past(encStatus.syncMono)
        && host_input_word[IW_SYNC_ERR] == $past(encStatus.syncErr);
  endproperty
  a_statusCopy: assert property (p_statusCopy) else $error("Status bits wrong");

  property p_notActiveWord;
    @(posedge clock) disable iff (sys_rst)
      ringNotActive == !host_input_word[IW_ACTIVE];
  endproperty
  a_notActiveWord: assert property (p_notActiveWord) else $error("Status sources differ");

  c_run: cover property (@(posedge clock) disable iff (sys_rst) $rose(pulseEnable));
  c_err: cover property (@(posedge clock) disable iff (sys_rst) $rose(paramError));
  c_bitOff: cover property (@(posedge clock) disable iff (sys_rst) pulseEnable ##1 xferBit);
  c_boot: cover property (@(posedge clock) disable iff (sys_rst) $fell(boot_q) && moduleActive);
  c_swCycle: cover property (@(posedge clock) disable iff (sys_rst) !boot_q && !swPrev_q && swLvl);
endmodule // raac_core
`default_nettype wire

// ### sim/raac_ring_master.sv
// Ring link master model: sends the start sequence on request
// Assumes the core's clock; request is a one-cycle level
`timescale 1ns/1ps
`default_nettype none
module raac_ring_master (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic startReq,
  input wire logic [7:0] delayCycles,
  output logic ringStartSeq
);
  int cnt_q;
  // Start pulse after a prompt or slow delay
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= -1;
      ringStartSeq <= 1'b0;
    end else begin
      ringStartSeq <= (cnt_q == 0);
      if (startReq)
        cnt_q <= int'(delayCycles);
      else if (cnt_q >= 0)
        cnt_q <= cnt_q - 1;
    end
  end
endmodule // raac_ring_master
`default_nettype wire

// ### sim/tb_receive_address_activation_control.sv
// Bench for the receive address activation control core
// Assumes raac_pkg and the ring master model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_receive_address_activation_control;
  import raac_pkg::*;
  typedef struct packed {
    raac_rxaddr_type rx;
    logic [CFG_W-1:0] cfg;
    logic [WORD_W-1:0] iw;
  } raac_note_type;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic actSw = 1'b1;
  logic [CHAN_W-1:0] chanSw = 3'h5;
  logic [ADDR_W-1:0] addrSw = 8'hb4;
  logic [CFG_W-1:0] cfgSw = 8'h3c;
  logic [WORD_W-1:0] outWord = 16'h0000;
  logic startReq = 1'b0;
  logic [7:0] dlyCyc = 8'h00;
  logic ringStart, active, pulseEn, notActive, paramErr, errLed;
  logic actPrev_q = 1'b0;
  raac_status_type encStatus = 4'ha;
  raac_rxaddr_type rxAddr;
  logic [CFG_W-1:0] cfgAct;
  logic [WORD_W-1:0] inWord;
  raac_note_type notes[$];
  raac_note_type got;
  int badCount = 0;
  int nCompared = 0;
  int seedVal = 37662;
  int r;
  logic err;

  initial begin
    forever #(CLK_PERIOD_NS / 2) clock = ~clock;
  end

  raac_core u_dut (
    .clock(clock),
    .sys_rst(sys_rst),
    .activation_switch(actSw),
    .channel_switch_bank(chanSw),
    .address_switch_bank(addrSw),
    .configSwitches(cfgSw),
    .host_output_word(outWord),
    .ringStartSeq(ringStart),
    .encStatus(encStatus),
    .rxAddr(rxAddr),
    .configActive(cfgAct),
    .moduleActive(active),
    .pulseEnable(pulseEn),
    .ringNotActive(notActive),
    .paramError(paramErr),
    .errorLed(errLed),
    .host_input_word(inWord)
  );
  raac_ring_master u_ring (
    .clock(clock),
    .sys_rst(sys_rst),
    .startReq(startReq),
    .delayCycles(dlyCyc),
    .ringStartSeq(ringStart)
  );

  task automatic tally_and_finish;
    $display("Compared %0d, mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [WORD_W-1:0] g, input logic [WORD_W-1:0] e);
    nCompared++;
    if (g !== e) begin
      badCount++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic abort_run;
    badCount++;
    $display("Error at %0t: wait ran out", $time);
    tally_and_finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Expected result of the next activation
  task automatic note(output logic e);
    raac_note_type n;
    n.rx.chan = chanSw | outWord[OW_CHAN_HI:OW_CHAN_LO];
    n.rx.addr = addrSw | outWord[OW_ADDR_HI:OW_ADDR_LO];
    n.cfg = cfgSw;
    e = (n.rx.addr > ADDR_MAX_DEF) || (n.rx.chan > CHAN_MAX_DEF);
    n.iw = IW_FIXED | {10'h000, e, encStatus.syncErr, encStatus.syncMono,
      encStatus.pulseMode, 1'b1, encStatus.syncToggle};
    notes.push_back(n);
  endtask

  task automatic activate(input logic [7:0] dly, input logic e);
    int i;
    for (i = 0; i < 12 && active !== 1'b1; i++) cyc(1);
    if (i == 12) abort_run;
    cyc(3);
    cmp(pulseEn, 1'b0);
    dlyCyc = dly;
    startReq = 1'b1;
    cyc(1);
    startReq = 1'b0;
    for (i = 0; i < 24 && pulseEn !== 1'b1; i++) cyc(1);
    if (i == 24 && !e) abort_run;
    cmp(pulseEn, !e);
  endtask

  task automatic xfer(input logic [WORD_W-1:0] w, input logic [7:0] dly);
    logic e;
    outWord = w | 16'h8000;
    cyc(5);
    cmp({active, pulseEn, notActive, inWord[IW_ACTIVE]}, 4'h2);
    note(e);
    outWord = w;
    activate(dly, e);
  endtask

  // Checks each activation against the oldest note
  always @(negedge clock) begin
    if (active === 1'b1 && actPrev_q === 1'b0) begin
      got = notes.pop_front();
      cmp(rxAddr, got.rx);
      cmp(cfgAct, got.cfg);
      cmp(inWord, got.iw);
      cmp({errLed, paramErr}, {2{got.iw[IW_PARAM_ERR]}});
    end
    actPrev_q <= active;
  end

  initial begin
    note(err);
    outWord = 16'h0003;
    cyc(6);
    sys_rst = 1'b0;
    activate(8'h00, err);
    addrSw = 8'h00;
    cfgSw = 8'hff;
    outWord = 16'h00ff;
    cyc(6);
    cmp(rxAddr, 11'h5b4);
    cmp(active, 1'b1);
    addrSw = 8'hb4;
    xfer(16'h0132, 8'h02);
    repeat (3) begin
      r = $random(seedVal);
      chanSw = r[18:16];
      addrSw = 8'h40;
      cfgSw = r[31:24];
      encStatus = r[23:20];
      xfer({5'h00, r[10:8], 2'b00, r[5:0]}, {4'h0, r[15:12]});
    end
    chanSw = 3'h1;
    for (int k = 0; k < 2; k++) begin
      addrSw = 8'hc8 + 8'(k);
      xfer(16'h0000, 8'h00);
    end
    actSw = 1'b0;
    cyc(5);
    cmp({active, pulseEn, notActive, inWord[IW_ACTIVE]}, 4'h2);
    outWord = 16'h8000;
    cyc(4);
    outWord = 16'h0000;
    cyc(6);
    cmp(active, 1'b0);
    addrSw = 8'h12;
    note(err);
    actSw = 1'b1;
    activate(8'h01, err);
    cyc(4);
    tally_and_finish;
  end
endmodule // tb_receive_address_activation_control
`default_nettype wire
